// ==== verilog/ctml_pkg.sv ====
// Shared constants for the coax transceiver message logic
`default_nettype none
package ctml_pkg;
   // ===============================================
   // Clock and bit timing
   // ===============================================
   localparam int CLK_MHZ = 100; // System clock rate
   localparam int BIT_NS = 100; // One Manchester bit cell at 10 Mb/s
   localparam int BIT_CYC = (BIT_NS * CLK_MHZ) / 1000; // Cycles per bit cell
   localparam int SQE_TEST_BITS = 10; // Post-frame test length in bit cells
   localparam int SQE_TEST_CYC = SQE_TEST_BITS * BIT_CYC; // Test length in cycles
   localparam int SQE_GAP_NS = 1000; // Idle-to-test delay, inside 0.6 to 1.6 us
   localparam int SQE_GAP_CYC = (SQE_GAP_NS * CLK_MHZ) / 1000; // Delay in cycles
   localparam int JABBER_MS = 50; // Transmit window, inside 20 to 150 ms
   localparam int JABBER_CYC = JABBER_MS * 1000 * CLK_MHZ; // Window in cycles
   // ===============================================
   // Code symbols on the attachment circuits
   // ===============================================
   localparam logic [1:0] SYM_IDL = 2'h0; // Idle
   localparam logic [1:0] SYM_CD0 = 2'h1; // Data zero
   localparam logic [1:0] SYM_CD1 = 2'h2; // Data one
   localparam logic [1:0] SYM_CS0 = 2'h3; // Control signal zero
   // ===============================================
   // Transmit sequence states
   // ===============================================
   typedef enum logic [1:0] {TX_IDLE, TX_ACTIVE, TX_GAP, TX_SQE} ctml_tx_state_t;
endpackage
`default_nettype wire

// ==== verilog/ctml_pair_buf.sv ====
// Small valid/ready buffer between station output and trunk driver
`timescale 1ns/1ps
`default_nettype none
module ctml_pair_buf #(
   parameter int WIDTH = 1, // Word width
   parameter int DEPTH = 2 // Entries
) (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic inValid, // Word offered
   input wire logic [WIDTH-1:0] inData, // Offered word
   output logic inReady, // Room for a word
   output logic outValid, // Word available
   output logic [WIDTH-1:0] outData, // Oldest word
   input wire logic outReady // Drain accepts word
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // Pointer width
   localparam int CW = $clog2(DEPTH + 1); // Count width
   logic [WIDTH-1:0] mem [DEPTH]; // Storage
   logic [PW-1:0] wrPtr_r; // Write slot
   logic [PW-1:0] rdPtr_r; // Read slot
   logic [CW-1:0] count_r; // Words held
   logic push; // Word written this cycle
   logic pop; // Word read this cycle

   // Wrap a pointer at the buffer end
   function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
      nextPtr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   // ===============================================
   // Handshake
   // ===============================================
   // Honest flags: full stalls the station, empty idles the driver
   assign inReady = (count_r != CW'(DEPTH));
   assign outValid = (count_r != '0);
   assign outData = mem[rdPtr_r];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // Storage write, no reset needed on data
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wrPtr_r] <= inData;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wrPtr_r <= nextPtr(wrPtr_r);
         end
         if (pop)
         begin
            rdPtr_r <= nextPtr(rdPtr_r);
         end
         if (push && !pop)
         begin
            count_r <= count_r + CW'(1);
         end
         else if (pop && !push)
         begin
            count_r <= count_r - CW'(1);
         end
      end
   end
endmodule // ctml_pair_buf
`default_nettype wire

// ==== verilog/ctml_message_logic.sv ====
// Message logic of a coax medium attachment unit: data, idle, isolate, SQE, jabber
`timescale 1ns/1ps
`default_nettype none
module ctml_message_logic #(
   parameter int unsigned JABBER_CYC = ctml_pkg::JABBER_CYC // Transmit window in cycles
) (
   input wire logic clk, // 100 MHz system clock
   input wire logic rst, // Async reset, active high
   input wire logic doStb, // Station symbol on data out
   input wire logic [1:0] doSym, // Data out symbol
   output logic doReady, // Buffer room for data out
   input wire logic [1:0] coSym, // Control out symbol level
   output logic [1:0] diSym, // Data in symbol
   output logic diStb, // Data in symbol strobe
   output logic [1:0] ciSym, // Control in symbol
   input wire logic rxValid, // Trunk receiver bit valid
   input wire logic rxBit, // Trunk receiver bit
   input wire logic rxActive, // Trunk carrier present
   input wire logic collDetect, // Analog collision detector, async
   output logic txValid, // Bit to trunk driver
   output logic txBit, // Trunk driver bit
   input wire logic txReady, // Trunk driver takes bit
   output logic txDriverEn, // Normal driver path active
   output logic txPosDisable // Positive transmitter disable
);
   import ctml_pkg::*;

   // ===============================================
   // Declarations
   // ===============================================
   localparam int SQE_W = $clog2(SQE_TEST_CYC + SQE_GAP_CYC + 1); // Sequence counter width
   ctml_tx_state_t txState_r; // Transmit sequence state
   logic [SQE_W-1:0] seqCnt_r; // Gap and test counter
   logic [31:0] jabCnt_r; // Continuous transmit time
   logic jabber_r; // Output inhibited by jabber
   logic isolate_r; // Isolate request held
   logic collSync1_r; // Detector first stage
   logic collSync2_r; // Detector second stage
   logic sqeReq; // Some cause of SQE present
   logic txEn; // Trunk output allowed
   logic isData; // Station offers a data symbol
   logic bufInValid; // Word into buffer
   logic bufOutValid; // Word from buffer
   logic bufOutData; // Buffered bit
   logic bufOutReady; // Driver stage drains buffer
   logic bufInReady; // Buffer has room
   logic diStb_r; // Data in strobe
   logic [1:0] diSym_r; // Data in symbol
   logic [1:0] ciSym_r; // Control in symbol
   logic txValid_r; // Driver bit valid
   logic txBit_r; // Driver bit
   logic txDriverEn_r; // Driver path enable
   logic doReady_r; // Registered buffer room

   assign isData = doStb && (doSym == SYM_CD0 || doSym == SYM_CD1);
   assign txEn = !isolate_r && !jabber_r;
   // Collision, SQE test and jabber all show as one control-in error
   assign sqeReq = collSync2_r || (txState_r == TX_SQE) || jabber_r;

   // ===============================================
   // Control out: isolate and normal
   // ===============================================
   // Held as a level; IDL returns the unit to the normal state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         isolate_r <= 1'b0;
      end
      else
      begin
         isolate_r <= (coSym == SYM_CS0);
      end
   end

   // ===============================================
   // Collision detector synchroniser
   // ===============================================
   // Analog comparator is asynchronous; only the second stage is read
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         collSync1_r <= 1'b0;
         collSync2_r <= 1'b0;
      end
      else
      begin
         collSync1_r <= collDetect;
         collSync2_r <= collSync1_r;
      end
   end

   // ===============================================
   // Transmit sequence and post-frame SQE test
   // ===============================================
   // Frame ends on an IDL strobe; gap, then a ten-cell test
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         txState_r <= TX_IDLE;
         seqCnt_r <= '0;
      end
      else
      begin
         unique case (txState_r)
            TX_IDLE:
            begin
               // First data symbol opens a frame
               if (isData)
               begin
                  txState_r <= TX_ACTIVE;
               end
            end
            TX_ACTIVE:
            begin
               // Output idle closes the frame
               if (doStb && doSym == SYM_IDL)
               begin
                  txState_r <= TX_GAP;
                  seqCnt_r <= SQE_W'(SQE_GAP_CYC - 1);
               end
            end
            TX_GAP:
            begin
               // Data restarting cancels the pending test
               if (isData)
               begin
                  txState_r <= TX_ACTIVE;
               end
               else if (seqCnt_r == '0)
               begin
                  txState_r <= TX_SQE;
                  seqCnt_r <= SQE_W'(SQE_TEST_CYC - 1);
               end
               else
               begin
                  seqCnt_r <= seqCnt_r - SQE_W'(1);
               end
            end
            TX_SQE:
            begin
               // Test runs its full length even if data returns
               if (seqCnt_r == '0)
               begin
                  txState_r <= TX_IDLE;
               end
               else
               begin
                  seqCnt_r <= seqCnt_r - SQE_W'(1);
               end
            end
         endcase
      end
   end

   // ===============================================
   // Jabber timer
   // ===============================================
   // Unit has a monitor, so only an isolate request clears the inhibit
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         jabCnt_r <= '0;
         jabber_r <= 1'b0;
      end
      else
      begin
         if (isolate_r)
         begin
            jabber_r <= 1'b0;
            jabCnt_r <= '0;
         end
         else if (txState_r == TX_ACTIVE && !jabber_r)
         begin
            // Window expired: stop further output
            if (jabCnt_r >= JABBER_CYC - 1)
            begin
               jabber_r <= 1'b1;
            end
            jabCnt_r <= jabCnt_r + 32'h1;
         end
         else if (txState_r != TX_ACTIVE)
         begin
            jabCnt_r <= '0;
         end
      end
   end

   // ===============================================
   // Transmit data path
   // ===============================================
   assign bufInValid = isData;
   // Disabled output still drains, so the station is never stuck
   assign bufOutReady = !txValid_r || txReady || !txEn;

   ctml_pair_buf #(
      .WIDTH(1),
      .DEPTH(2)
   ) u_buf (
      .clk(clk),
      .rst(rst),
      .inValid(bufInValid),
      .inData(doSym == SYM_CD1),
      .inReady(bufInReady),
      .outValid(bufOutValid),
      .outData(bufOutData),
      .outReady(bufOutReady)
   );

   // Driver stage; isolate or jabber drops the bit at once
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         txValid_r <= 1'b0;
         txBit_r <= 1'b0;
         txDriverEn_r <= 1'b0;
         doReady_r <= 1'b0;
      end
      else
      begin
         if (!txEn)
         begin
            txValid_r <= 1'b0;
         end
         else if (!txValid_r || txReady)
         begin
            txValid_r <= bufOutValid;
            txBit_r <= bufOutData;
         end
         txDriverEn_r <= txEn && (txState_r == TX_ACTIVE);
         doReady_r <= bufInReady;
      end
   end

   // ===============================================
   // Receive path and control in
   // ===============================================
   // One output register, no bit-cell resampling; isolate not consulted
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         diSym_r <= SYM_IDL;
         diStb_r <= 1'b0;
         ciSym_r <= SYM_IDL;
      end
      else
      begin
         diStb_r <= rxValid;
         if (rxValid)
         begin
            diSym_r <= rxBit ? SYM_CD1 : SYM_CD0;
         end
         else if (!rxActive)
         begin
            diSym_r <= SYM_IDL;
         end
         // Runs whether or not the station sends data
         ciSym_r <= sqeReq ? SYM_CS0 : SYM_IDL;
      end
   end

   assign diSym = diSym_r;
   assign diStb = diStb_r;
   assign ciSym = ciSym_r;
   assign txValid = txValid_r;
   assign txBit = txBit_r;
   assign txDriverEn = txDriverEn_r;
   assign txPosDisable = isolate_r;
   assign doReady = doReady_r;

   // ===============================================
   // Checks
   // ===============================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Disable flag follows one edge later; driver stage drops one edge after that
   isolate_disable_a: assert property (
      (coSym == SYM_CS0) |=> txPosDisable ##1 (!txValid && !txDriverEn)) else $error("isolate did not disable");
   normal_release_a: assert property (
      (coSym == SYM_IDL) |=> !txPosDisable) else $error("normal left disable on");
   rx_map_a: assert property (
      rxValid |=> diStb && (diSym == ($past(rxBit) ? SYM_CD1 : SYM_CD0))) else $error("bad data in symbol");
   rx_idle_a: assert property (
      (!rxValid && !rxActive) |=> (diSym == SYM_IDL) && !diStb) else $error("data in not idle");
   ci_state_a: assert property (
      !sqeReq |=> (ciSym == SYM_IDL)) else $error("control in not idle");
   coll_on_a: assert property (
      collDetect[*3] |-> ##[0:1] (ciSym == SYM_CS0)) else $error("collision not reported");
   coll_off_a: assert property (
      ((!collDetect)[*4] ##0 (txState_r != TX_SQE) && !jabber_r) |=> (ciSym == SYM_IDL))
      else $error("sqe not removed");
   sqe_test_a: assert property (
      $rose(txState_r == TX_SQE) |-> ##99 (txState_r == TX_SQE) ##1 (txState_r != TX_SQE))
      else $error("sqe test length wrong");
   sqe_start_a: assert property (
      ($rose(txState_r == TX_GAP) ##1 (!isData)[*8]) |-> ##[90:92] (txState_r == TX_SQE || isData))
      else $error("sqe test not started");
   jabber_sqe_a: assert property (
      jabber_r |=> (ciSym == SYM_CS0) && !txValid) else $error("jabber not signalled");
   rx_isolated_a: assert property (
      (txPosDisable && rxValid) |=> diStb) else $error("isolate blocked receive");

   frame_test_c: cover property ($rose(txState_r == TX_SQE));
   collision_c: cover property ($rose(collSync2_r) && txState_r == TX_ACTIVE);
   isolate_c: cover property ($rose(txPosDisable) && rxValid);
   stall_c: cover property (!doReady && doStb);
endmodule // ctml_message_logic
`default_nettype wire

// ==== verification/ctml_station_model.sv ====
// Station-side model driving the data-out and control-out circuits
`timescale 1ns/1ps
`default_nettype none
module ctml_station_model (
   input wire logic clk, // System clock
   input wire logic doReady, // Room in the unit's buffer
   output logic doStb, // Symbol strobe
   output logic [1:0] doSym, // Data-out symbol
   output logic [1:0] coSym // Control-out symbol
);
   import ctml_pkg::*;
   // ===============================================
   // Idle levels
   // ===============================================
   initial
   begin
      doStb = 1'b0;
      doSym = SYM_IDL; // Nothing to send
      coSym = SYM_IDL; // Normal mode
   end
   // ===============================================
   // Symbol transfer
   // ===============================================
   // Waits for room first: a strobe while full would be dropped
   task automatic put_sym(input logic [1:0] s, input int gap);
      int k;
      k = 0;
      @(negedge clk);
      while (doReady !== 1'b1 && k < 2000)
      begin
         @(negedge clk);
         k++;
      end
      doStb = 1'b1;
      doSym = s; // Data as CD0/CD1, IDL closes the frame
      @(negedge clk);
      doStb = 1'b0;
      doSym = SYM_IDL; // Idle between strobes
      repeat (gap) @(negedge clk);
   endtask
   // One data bit as a code symbol
   task automatic send_bit(input logic b, input int gap);
      put_sym(b ? SYM_CD1 : SYM_CD0, gap);
   endtask
   // Isolate request or normal level on control out
   task automatic set_isolate(input logic on);
      @(negedge clk);
      coSym = on ? SYM_CS0 : SYM_IDL;
   endtask
endmodule // ctml_station_model
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking testbench for the coax transceiver message logic
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ctml_pkg::*;
   // ===============================================
   // Signals
   // ===============================================
   localparam int unsigned JAB = 200; // Short jabber window keeps the run brief
   logic clk, rst, doStb, doReady, txReady, rxValid, rxBit, rxActive, collDetect;
   logic txValid, txBit, txDriverEn, txPosDisable, diStb;
   logic [1:0] doSym, coSym, diSym, ciSym;
   int n_errors = 0; // Mismatches
   int num_checks = 0; // Comparisons
   logic txQ[$]; // Bits seen leaving toward the trunk
   int n; // Wait counts
   // ===============================================
   // Clock, units
   // ===============================================
   initial clk = 1'b0;
   always #5 clk = ~clk;
   ctml_message_logic #(.JABBER_CYC(JAB)) u_dut (.clk(clk), .rst(rst), .doStb(doStb), .doSym(doSym),
      .doReady(doReady), .coSym(coSym), .diSym(diSym), .diStb(diStb), .ciSym(ciSym), .rxValid(rxValid),
      .rxBit(rxBit), .rxActive(rxActive), .collDetect(collDetect), .txValid(txValid), .txBit(txBit),
      .txReady(txReady), .txDriverEn(txDriverEn), .txPosDisable(txPosDisable));
   ctml_station_model u_sta (.clk(clk), .doReady(doReady), .doStb(doStb), .doSym(doSym), .coSym(coSym));
   // Trunk driver: collect every accepted bit
   always @(posedge clk)
   begin
      if (txValid === 1'b1 && txReady === 1'b1)
      begin
         txQ.push_back(txBit);
      end
   end
   // ===============================================
   // Compare and wait helpers
   // ===============================================
   task automatic chk_sym(input logic [1:0] got, input logic [1:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %0t symbol got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %0t value got %h expected %h", $time, got, exp);
      end
   endtask
   // Counts falling edges until control-in shows the symbol, bounded
   task automatic wait_ci(input logic [1:0] s, input int lim, output int cnt);
      cnt = 0;
      while (ciSym !== s && cnt < lim)
      begin
         @(negedge clk);
         cnt++;
      end
   endtask
   // ===============================================
   // Scenarios
   // ===============================================
   task automatic t_reset;
      @(negedge clk);
      chk_sym(ciSym, SYM_IDL);
      chk_sym(diSym, SYM_IDL);
      chk_val(txPosDisable, 0);
      $display("t_reset done");
   endtask
   // Frame with a stalled driver, then the post-frame test
   task automatic t_frame;
      logic [5:0] pat;
      pat = 6'h2D;
      txReady = 1'b0;
      txQ.delete();
      fork
         begin
            for (int i = 5; i >= 0; i--) u_sta.send_bit(pat[i], 0);
            u_sta.put_sym(SYM_IDL, 0);
         end
         begin
            repeat (40) @(negedge clk);
            chk_val(doReady, 0); // Buffer refuses while full
            chk_val(txDriverEn, 1);
            // Remote transmitter joins while the frame is open
            collDetect = 1'b1;
            repeat (4) @(negedge clk);
            chk_sym(ciSym, SYM_CS0);
            collDetect = 1'b0;
            repeat (4) @(negedge clk);
            chk_sym(ciSym, SYM_IDL);
            txReady = 1'b1;
         end
      join
      wait_ci(SYM_CS0, 300, n);
      chk_val((n >= 60 && n <= 160), 1);
      wait_ci(SYM_IDL, 300, n);
      chk_val(n, SQE_TEST_CYC);
      chk_val(txQ.size(), 6);
      for (int i = 0; i < 6 && i < txQ.size(); i++) chk_val(txQ[i], pat[5-i]);
      chk_val(txDriverEn, 0);
      $display("t_frame done");
   endtask
   // Two received bits then carrier loss, optionally while isolated
   task automatic t_receive(input logic iso);
      u_sta.set_isolate(iso);
      repeat (3) @(negedge clk);
      chk_val(txPosDisable, iso);
      rxActive = 1'b1;
      for (int b = 1; b >= 0; b--)
      begin
         rxValid = 1'b1;
         rxBit = b[0];
         @(negedge clk);
         // Strobe stands for one cycle only, so look at it now
         chk_val(diStb, 1);
         chk_sym(diSym, b ? SYM_CD1 : SYM_CD0);
         rxValid = 1'b0;
         @(negedge clk);
         chk_val(diStb, 0);
      end
      chk_sym(ciSym, SYM_IDL);
      rxActive = 1'b0;
      repeat (2) @(negedge clk);
      chk_sym(diSym, SYM_IDL);
      u_sta.set_isolate(1'b0);
      $display("t_receive done");
   endtask
   // Collision with no station data at all
   task automatic t_collision;
      collDetect = 1'b1;
      wait_ci(SYM_CS0, 100, n);
      chk_val(n < 9 * BIT_CYC, 1);
      repeat (50) @(negedge clk);
      chk_sym(ciSym, SYM_CS0);
      collDetect = 1'b0;
      wait_ci(SYM_IDL, 300, n);
      chk_val(n <= 20 * BIT_CYC, 1);
      $display("t_collision done");
   endtask
   // Overlong frame trips the jabber inhibit; isolate clears it
   task automatic t_jabber;
      txReady = 1'b1;
      txQ.delete();
      for (int i = 0; i < 40; i++) u_sta.send_bit(i[0], 9);
      chk_sym(ciSym, SYM_CS0);
      chk_val(txValid, 0);
      chk_val(txQ.size() < 40, 1);
      u_sta.put_sym(SYM_IDL, 0);
      u_sta.set_isolate(1'b1);
      repeat (300) @(negedge clk);
      u_sta.set_isolate(1'b0);
      repeat (5) @(negedge clk);
      chk_sym(ciSym, SYM_IDL);
      $display("t_jabber done");
   endtask
   // ===============================================
   // Run control
   // ===============================================
   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      rst = 1'b1;
      {txReady, rxValid, rxBit, rxActive, collDetect} = 5'h00;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_frame();
      t_receive(1'b0);
      t_receive(1'b1);
      t_collision();
      t_jabber();
      give_verdict();
   end
   // Watchdog well beyond the roughly 1100 cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
endmodule // tb
`default_nettype wire
